//--- core/bcm_buck_switch_control.sv
// Switching and protection control of a boundary-conduction buck LED driver.
//
// Overview of operation
// - Start a new on-phase once inductor current returned to zero.
// - During on-phase, peak-current indication turns switch off into secondary stroke.
// - After secondary stroke, valley indication starts next cycle.
// - Valley counts only if ring frequency and swing qualifiers are valid.
// - Without valid valley, stay off until maximum off-time, then restart.
// - Shorted-coil and output-short faults latch halt until supply below clear level.
// - Overtemperature faults halt, wait for supply stop, restart when fault gone.
// - Supply below stop level stops switching and requests high-voltage restart.
// - Ignore overcurrent and shorted-coil indications during blanking after turn-on.
// - Peak detector acts on threshold, evaluated only after blanking.
// - Die overtemperature stops switching; resume only below release level.
// - Internal maximum on-time ends on-phase even without peak current.
// - External on-time threshold before internal limit ends on-phase.
// - Missing or grounded on-time capacitor: external indication ignored.
// - Sense above shorted-coil threshold after blanking enters latched halt.
// - Output-short timer starts at off-time expiry, stops on valid valley.
// - Output-short timer reaching detect time latches halt.
// - While dimmed off, output-short timer holds its count.
// - Temperature input low past timeout declares LED overtemperature until high.
// - Temperature input pulled low within timeout dims output to zero.
// - Peak current scales from nominal to half between high and low levels.
`default_nettype none
module bcm_buck_switch_control
  import bcm_ctrl_pkg::*;
#(
  parameter int ON_MAX      = ON_MAX_CYCLES,
  parameter int OFF_MAX     = OFF_MAX_CYCLES,
  parameter int BLANK       = BLANK_CYCLES,
  parameter int SHORT_DET   = SHORT_DETECT_CYCLES,
  parameter int NTC_TIMEOUT = NTC_TIMEOUT_CYCLES
) (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rstn,
  // Power stage comparators
  input  wire logic                    zeroCurrent,
  input  wire logic                    valleyDetect,
  input  wire logic                    ringFreqOk,
  input  wire logic                    swingOk,
  input  wire logic                    peakCurrent,
  input  wire logic                    shortedCoilLevel,
  input  wire logic                    onTimePinThreshold,
  input  wire logic                    onTimeCapPresent,
  // Supply and temperature comparators
  input  wire logic                    supplyAboveStop,
  input  wire logic                    supplyAboveClear,
  input  wire logic                    dieHot,
  input  wire logic                    dieCool,
  input  wire logic                    ntcAboveHigh,
  input  wire logic                    ntcAboveLow,
  input  wire logic                    ntcAboveAct,
  input  wire logic                    ntcAboveDeact,
  input  wire logic [PEAK_LEVEL_W-1:0] ntcRampLevel,
  // Outputs
  output logic                         switchDrive,
  output logic                         highVoltageStartupReq,
  output logic      [PEAK_LEVEL_W-1:0] peakLevel,
  output logic                         latchedHalt,
  output logic                         safeRestartHalt,
  output logic                         dimmedOff
);
  // ==========================================================================
  // Synchronisation
  // ==========================================================================
  localparam int NS = 16;
  logic [NS-1:0]           rawIn;
  logic [NS-1:0]           syncIn;
  logic [PEAK_LEVEL_W-1:0] rampSync1;
  logic [PEAK_LEVEL_W-1:0] rampSync;
  // Multi-bit ramp level is a slow analog quantity, so a per-bit sync is tolerable.
  assign rawIn = {zeroCurrent, valleyDetect, ringFreqOk, swingOk, peakCurrent,
                  shortedCoilLevel, onTimePinThreshold, onTimeCapPresent,
                  supplyAboveStop, supplyAboveClear, dieHot, dieCool,
                  ~ntcAboveHigh, ~ntcAboveLow, ~ntcAboveAct, ~ntcAboveDeact};

  bcm_sync #(.W(NS)) u_sync (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .asyncIn (rawIn),
    .syncOut (syncIn)
  );
  bcm_sync #(.W(PEAK_LEVEL_W)) u_sync_ramp (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .asyncIn (ntcRampLevel),
    .syncOut (rampSync)
  );
  assign rampSync1 = rampSync;

  logic sZero, sValley, sRing, sSwing, sPeak, sCoil, sOnPin, sCap;
  logic sStop, sClear, sHot, sCool, sHighN, sLowN, sActN, sDeactN;
  logic sHigh, sLow, sAct, sDeact;
  assign {sZero, sValley, sRing, sSwing, sPeak, sCoil, sOnPin, sCap,
          sStop, sClear, sHot, sCool, sHighN, sLowN, sActN, sDeactN} = syncIn;
  // The temperature comparators idle high, so they cross inverted: a freshly reset
  // bank then reads as an idle pin rather than as a pulled-down one that would dim.
  assign sHigh  = !sHighN;
  assign sLow   = !sLowN;
  assign sAct   = !sActN;
  assign sDeact = !sDeactN;

  // ==========================================================================
  // Temperature input monitor
  // ==========================================================================
  logic ledHot;
  logic ntcDim;
  bcm_ntc_monitor #(.NTC_TIMEOUT(NTC_TIMEOUT)) u_ntc (
    .ref_clk       (ref_clk),
    .rstn          (rstn),
    .ntcAboveHigh  (sHigh),
    .ntcAboveLow   (sLow),
    .ntcAboveAct   (sAct),
    .ntcAboveDeact (sDeact),
    .ntcRampLevel  (rampSync1),
    .ledOverTemp   (ledHot),
    .dimOff        (ntcDim),
    .peakLevel     (peakLevel)
  );

  if (ON_MAX < 2 || OFF_MAX < 2 || BLANK < 1 || SHORT_DET < 1) begin : g_bad_timing
    $error("timing parameters too small");
  end
  if (BLANK >= ON_MAX) begin : g_bad_blank
    $error("BLANK must be below ON_MAX");
  end

  // ==========================================================================
  // Decoding
  // ==========================================================================
  sw_state_e   state_reg;
  sw_state_e   state_next;
  logic [31:0] phaseCount_reg;
  logic [31:0] shortCount_reg;
  logic        shortRun_reg;
  logic        latch_reg;
  logic        dieHot_reg;
  logic        safe_reg;
  logic        lockout_reg;

  wire blanked      = phaseCount_reg < 32'(BLANK);
  wire validValley  = sValley && sRing && sSwing;
  wire onMaxHit     = phaseCount_reg >= 32'(ON_MAX - 1);
  wire extOnHit     = sOnPin && sCap;
  wire peakHit      = !blanked && sPeak;
  wire coilFault    = (state_reg == ST_ON) && !blanked && sCoil;
  wire offMaxHit    = (state_reg == ST_SEC) && phaseCount_reg >= 32'(OFF_MAX - 1);
  wire shortExpired = shortRun_reg && shortCount_reg >= 32'(SHORT_DET - 1);
  wire anyHalt      = latch_reg || safe_reg || lockout_reg || dieHot_reg;
  wire runAllowed   = !anyHalt && !ntcDim;
  wire turnOff      = peakHit || onMaxHit || extOnHit;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_HALT: state_next = runAllowed ? ST_WAIT : ST_HALT;
      ST_WAIT: state_next = sZero ? ST_ON : ST_WAIT;
      ST_ON:   state_next = turnOff ? ST_SEC : ST_ON;
      ST_SEC: begin
        if (validValley || offMaxHit) begin
          state_next = ST_ON;
        end
      end
      default: state_next = ST_HALT;
    endcase
    if (!runAllowed || coilFault) begin
      state_next = ST_HALT;
    end
  end

  // ==========================================================================
  // State and phase timer
  // ==========================================================================
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg      <= ST_HALT;
      phaseCount_reg <= '0;
    end else begin
      state_reg      <= state_next;
      phaseCount_reg <= (state_next != state_reg) ? 32'd0 : phaseCount_reg + 32'd1;
    end
  end

  // ==========================================================================
  // Output-short timer
  // ==========================================================================
  // A supply reset clears the timer as well; an expired count would otherwise re-latch at once.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      shortRun_reg   <= 1'b0;
      shortCount_reg <= '0;
    end else if (!sClear) begin
      shortRun_reg   <= 1'b0;
      shortCount_reg <= '0;
    end else if (state_reg == ST_SEC && validValley) begin
      shortRun_reg   <= 1'b0;
      shortCount_reg <= '0;
    end else if (offMaxHit && !shortRun_reg) begin
      shortRun_reg <= 1'b1;
    end else if (shortRun_reg && !ntcDim && !latch_reg) begin
      shortCount_reg <= shortCount_reg + 32'd1;
    end
  end

  // ==========================================================================
  // Protections
  // ==========================================================================
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      latch_reg   <= 1'b0;
      dieHot_reg  <= 1'b0;
      safe_reg    <= 1'b0;
      lockout_reg <= 1'b1;
    end else begin
      if (coilFault || shortExpired) begin
        latch_reg <= 1'b1;
      end else if (!sClear) begin
        latch_reg <= 1'b0;
      end
      if (sHot) begin
        dieHot_reg <= 1'b1;
      end else if (sCool) begin
        dieHot_reg <= 1'b0;
      end
      if (sHot || ledHot) begin
        safe_reg <= 1'b1;
      end else if (lockout_reg && !dieHot_reg) begin
        safe_reg <= 1'b0;
      end
      if (!sStop) begin
        lockout_reg <= 1'b1;
      end else if (!safe_reg && !ledHot) begin
        lockout_reg <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Output flops
  // ==========================================================================
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      switchDrive           <= 1'b0;
      highVoltageStartupReq <= 1'b1;
      latchedHalt           <= 1'b0;
      safeRestartHalt       <= 1'b0;
      dimmedOff             <= 1'b0;
    end else begin
      switchDrive           <= (state_next == ST_ON);
      highVoltageStartupReq <= !sStop || lockout_reg;
      latchedHalt           <= latch_reg;
      safeRestartHalt       <= safe_reg;
      dimmedOff             <= ntcDim;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  onehot_state_a: assert property ($onehot(state_reg))
    else $error("state not one-hot");
  halt_drive_a: assert property (latch_reg |=> !switchDrive)
    else $error("drive during latched halt");
  blank_peak_a: assert property (state_reg == ST_ON && blanked && !onMaxHit
    && !extOnHit && runAllowed && !coilFault |=> state_reg == ST_ON)
    else $error("turned off during blanking");
  peak_off_a: assert property (state_reg == ST_ON && peakHit |=> !switchDrive)
    else $error("peak did not end on-phase");
  onmax_off_a: assert property (state_reg == ST_ON && onMaxHit |=> state_reg != ST_ON)
    else $error("on-time limit ignored");
  offmax_on_a: assert property (offMaxHit && runAllowed |=> state_reg == ST_ON)
    else $error("off-time expiry did not restart");
  stop_halt_a: assert property (!sStop |=> ##1 state_reg == ST_HALT)
    else $error("no halt below stop level");
  short_latch_a: assert property (shortExpired |=> latch_reg)
    else $error("output short not latched");
  dim_hold_a: assert property (ntcDim && sClear && !offMaxHit && !validValley
    |=> $stable(shortCount_reg))
    else $error("short timer moved while dimmed");
  zero_start_a: assert property (state_reg == ST_WAIT && sZero && runAllowed
    |=> state_reg == ST_ON)
    else $error("zero current did not start on-phase");
  valley_on_a: assert property (state_reg == ST_SEC && validValley && runAllowed
    |=> state_reg == ST_ON)
    else $error("valid valley did not start on-phase");
  ext_on_a: assert property (state_reg == ST_ON && extOnHit
    |=> !switchDrive)
    else $error("on-time pin threshold ignored");
  coil_latch_a: assert property (coilFault |=> latch_reg)
    else $error("shorted coil not latched");
  latch_clear_a: assert property (latch_reg && !sClear && !coilFault
    && !shortExpired |=> !latch_reg)
    else $error("latch kept below clear level");
  die_stop_a: assert property (dieHot_reg |=> !switchDrive)
    else $error("drive while die hot");
  hv_req_a: assert property (!sStop |=> highVoltageStartupReq)
    else $error("no restart request below stop level");

  cycle_c: cover property (state_reg == ST_ON ##1 state_reg == ST_SEC ##[1:50] state_reg == ST_ON);
  latch_c: cover property ($rose(latch_reg));
  dim_c: cover property ($rose(ntcDim));
  safe_c: cover property ($rose(safe_reg));
endmodule : bcm_buck_switch_control // bcm_buck_switch_control
`default_nettype wire

//--- pkg/bcm_ctrl_pkg.sv
// Constants and types shared by the buck switching control.
`default_nettype none
package bcm_ctrl_pkg;
  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 10;
  localparam int BLANK_TIME_NS = 300;
  localparam int ON_MAX_TIME_NS = 16000;
  localparam int OFF_MAX_TIME_NS = 40000;
  localparam int SHORT_DETECT_TIME_US = 20000;
  localparam int NTC_TIMEOUT_US = 10000;
  localparam int BLANK_CYCLES = (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ON_MAX_CYCLES = ON_MAX_TIME_NS / CLK_PERIOD_NS;
  localparam int OFF_MAX_CYCLES = OFF_MAX_TIME_NS / CLK_PERIOD_NS;
  localparam int SHORT_DETECT_CYCLES = SHORT_DETECT_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int NTC_TIMEOUT_CYCLES = NTC_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
  localparam int PEAK_LEVEL_W = 4;
  localparam logic [PEAK_LEVEL_W-1:0] PEAK_FULL = 4'hf;
  localparam logic [PEAK_LEVEL_W-1:0] PEAK_HALF = 4'h8;

  // ==========================================================================
  // Switching states
  // ==========================================================================
  typedef enum logic [3:0] {
    ST_HALT = 4'h1,
    ST_WAIT = 4'h2,
    ST_ON   = 4'h4,
    ST_SEC  = 4'h8
  } sw_state_e;
endpackage : bcm_ctrl_pkg
`default_nettype wire

//--- core/bcm_sync.sv
// Two-flip-flop synchroniser bank for comparator indications.
`default_nettype none
module bcm_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  // Data
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] stage1_reg;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stage1_reg <= '0;
      syncOut    <= '0;
    end else begin
      stage1_reg <= asyncIn;
      syncOut    <= stage1_reg;
    end
  end
endmodule : bcm_sync // bcm_sync
`default_nettype wire

//--- core/bcm_ntc_monitor.sv
// Temperature input monitor: dim, overtemperature and peak scaling.
`default_nettype none
module bcm_ntc_monitor
  import bcm_ctrl_pkg::*;
#(
  parameter int NTC_TIMEOUT = NTC_TIMEOUT_CYCLES
) (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rstn,
  // Synchronised comparator levels
  input  wire logic                    ntcAboveHigh,
  input  wire logic                    ntcAboveLow,
  input  wire logic                    ntcAboveAct,
  input  wire logic                    ntcAboveDeact,
  input  wire logic [PEAK_LEVEL_W-1:0] ntcRampLevel,
  // Results
  output logic                         ledOverTemp,
  output logic                         dimOff,
  output logic      [PEAK_LEVEL_W-1:0] peakLevel
);
  logic [31:0] tmrCount;
  logic        tmrRun;
  logic        tmrExpired;
  logic        inDim;

  if (NTC_TIMEOUT < 1) begin : g_bad_timeout
    $error("NTC_TIMEOUT must be at least 1");
  end

  assign tmrExpired = tmrRun && (tmrCount >= 32'(NTC_TIMEOUT - 1));

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tmrCount    <= '0;
      tmrRun      <= 1'b0;
      ledOverTemp <= 1'b0;
      inDim       <= 1'b0;
    end else begin
      if (ntcAboveAct) begin
        tmrRun   <= 1'b0;
        tmrCount <= '0;
      end else if (!tmrRun && !inDim && !ledOverTemp) begin
        tmrRun <= 1'b1;
      end else if (tmrRun) begin
        tmrCount <= tmrCount + 32'd1;
      end
      if (tmrRun && !ntcAboveDeact && !tmrExpired) begin
        inDim  <= 1'b1;
        tmrRun <= 1'b0;
      end else if (ntcAboveDeact && inDim) begin
        inDim <= 1'b0;
      end
      if (tmrExpired) begin
        ledOverTemp <= 1'b1;
        tmrRun      <= 1'b0;
      end else if (ledOverTemp && ntcAboveHigh) begin
        ledOverTemp <= 1'b0;
      end
    end
  end

  assign dimOff = inDim;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      peakLevel <= PEAK_FULL;
    end else if (ntcAboveHigh) begin
      peakLevel <= PEAK_FULL;
    end else if (!ntcAboveLow) begin
      peakLevel <= PEAK_HALF;
    end else begin
      peakLevel <= (ntcRampLevel < PEAK_HALF) ? PEAK_HALF : ntcRampLevel;
    end
  end
endmodule : bcm_ntc_monitor // bcm_ntc_monitor
`default_nettype wire

//--- tb/power_stage_model.sv
// Behavioural model of the power stage that the switching control drives.
`default_nettype none
module power_stage_model (
  // Clock
  input  wire logic ref_clk,
  // Gate from the control
  input  wire logic switchDrive,
  // Behaviour set by the bench
  input  var  int   peakAfter,
  input  var  int   tonAfter,
  input  var  int   fallAfter,
  input  wire logic valleyOn,
  input  wire logic qualOk,
  // Comparator indications
  output logic      zeroCurrent,
  output logic      valleyDetect,
  output logic      ringFreqOk,
  output logic      swingOk,
  output logic      peakCurrent,
  output logic      onTimePinThreshold
);
  timeunit 1ns;
  timeprecision 100ps;
  int onCnt = 0;
  int offCnt = 0;
  // ==========================================================================
  // Current ramp and drain ringing
  // ==========================================================================
  // The valley pulse lasts three cycles so the two-stage synchroniser cannot miss it.
  always @(negedge ref_clk) begin
    if (switchDrive === 1'b1) begin
      onCnt++;
      offCnt = 0;
    end else begin
      offCnt++;
      onCnt = 0;
    end
    peakCurrent <= (onCnt >= peakAfter) && (onCnt > 0);
    onTimePinThreshold <= (onCnt >= tonAfter) && (onCnt > 0);
    zeroCurrent <= (offCnt >= fallAfter);
    valleyDetect <= valleyOn && (offCnt >= fallAfter + 2) && (offCnt < fallAfter + 5);
    ringFreqOk <= qualOk;
    swingOk <= qualOk;
  end
endmodule // power_stage_model
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the buck switching control.
`default_nettype none
module testbench import bcm_ctrl_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int ONM = 20;
  localparam int OFFM = 40;
  localparam int BLK = 3;
  localparam int LIMIT = 60000;
  logic ref_clk, rstn, zeroCurrent, valleyDetect, ringFreqOk, swingOk, peakCurrent;
  logic shortedCoil, onTimeThr, capPresent, stopOk, clearOk, dieHot, dieCool;
  logic nHigh, nLow, nAct, nDeact, valleyOn, qualOk;
  logic switchDrive, hvReq, latchedHalt, safeRestartHalt, dimmedOff;
  logic [PEAK_LEVEL_W-1:0] ramp, peakLevel;
  int peakAfter, tonAfter, fallAfter, w, on, off, cycles;
  int mismatches = 0;
  int checked = 0;

  bcm_buck_switch_control #(.ON_MAX(ONM), .OFF_MAX(OFFM), .BLANK(BLK), .SHORT_DET(200),
    .NTC_TIMEOUT(50)) uut (.ref_clk(ref_clk), .rstn(rstn), .zeroCurrent(zeroCurrent),
    .valleyDetect(valleyDetect), .ringFreqOk(ringFreqOk), .swingOk(swingOk),
    .peakCurrent(peakCurrent), .shortedCoilLevel(shortedCoil), .onTimePinThreshold(onTimeThr),
    .onTimeCapPresent(capPresent), .supplyAboveStop(stopOk), .supplyAboveClear(clearOk),
    .dieHot(dieHot), .dieCool(dieCool), .ntcAboveHigh(nHigh), .ntcAboveLow(nLow),
    .ntcAboveAct(nAct), .ntcAboveDeact(nDeact), .ntcRampLevel(ramp), .switchDrive(switchDrive),
    .highVoltageStartupReq(hvReq), .peakLevel(peakLevel), .latchedHalt(latchedHalt),
    .safeRestartHalt(safeRestartHalt), .dimmedOff(dimmedOff));

  power_stage_model stage (.ref_clk(ref_clk), .switchDrive(switchDrive), .peakAfter(peakAfter),
    .tonAfter(tonAfter), .fallAfter(fallAfter), .valleyOn(valleyOn), .qualOk(qualOk),
    .zeroCurrent(zeroCurrent), .valleyDetect(valleyDetect), .ringFreqOk(ringFreqOk),
    .swingOk(swingOk), .peakCurrent(peakCurrent), .onTimePinThreshold(onTimeThr));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic inr(input int v, input int lo, input int hi);
    return (v >= lo) && (v <= hi);
  endfunction

  function automatic logic flag(input int sel);
    case (sel)
      0: return latchedHalt;
      1: return safeRestartHalt;
      default: return dimmedOff;
    endcase
  endfunction

  task automatic waitFor(input int sel, input int lim);
    int n;
    n = 0;
    while (flag(sel) !== 1'b1 && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
  endtask

  // Lengths are counted in cycles; the search is bounded so a stuck switch cannot hang.
  task automatic cycleLen();
    w = 0;
    while (switchDrive !== 1'b1 && w < 3000) begin
      @(negedge ref_clk);
      w++;
    end
    on = 0;
    while (switchDrive === 1'b1 && on < 3000) begin
      @(negedge ref_clk);
      on++;
    end
    off = 0;
    while (switchDrive !== 1'b1 && off < 3000) begin
      @(negedge ref_clk);
      off++;
    end
  endtask

  task automatic supplyDrop(input logic deep);
    stopOk = 1'b0;
    clearOk = !deep;
    repeat (10) @(negedge ref_clk);
    clearOk = 1'b1;
    stopOk = 1'b1;
    repeat (10) @(negedge ref_clk);
  endtask

  task automatic summarize();
    if (mismatches == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // Clock and timeout
  // ==========================================================================
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    cycles = 0;
    forever begin
      @(posedge ref_clk);
      cycles++;
      if (cycles == LIMIT) begin
        mismatches++;
        summarize();
      end
    end
  end

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    rstn = 1'b0; shortedCoil = 1'b0; capPresent = 1'b1; stopOk = 1'b1; clearOk = 1'b1;
    dieHot = 1'b0; dieCool = 1'b1; nHigh = 1'b1; nLow = 1'b1; nAct = 1'b1; nDeact = 1'b1;
    ramp = 4'hf; peakAfter = 10; tonAfter = 1000; fallAfter = 4; valleyOn = 1'b1; qualOk = 1'b1;
    repeat (4) @(negedge ref_clk);
    check("resetDrive", switchDrive, 1'b0);
    check("resetHvReq", hvReq, 1'b1);
    check("resetPeak", peakLevel, 4'hf);
    rstn = 1'b1;
    cycleLen();
    check("firstStart", inr(w, 1, 30), 1'b1);
    cycleLen();
    check("peakOn", inr(on, 11, 15), 1'b1);
    check("valleyOff", inr(off, 1, OFFM - 1), 1'b1);
    check("runHvReq", hvReq, 1'b0);
    peakAfter = 0;
    cycleLen();
    check("blankOn", inr(on, BLK, BLK + 5), 1'b1);
    peakAfter = 1000;
    cycleLen();
    check("maxOn", inr(on, ONM, ONM + 4), 1'b1);
    tonAfter = 6;
    cycleLen();
    check("capOn", inr(on, 7, 11), 1'b1);
    capPresent = 1'b0;
    cycleLen();
    check("noCapOn", inr(on, ONM, ONM + 4), 1'b1);
    capPresent = 1'b1;
    tonAfter = 1000;
    peakAfter = 10;
    qualOk = 1'b0;
    repeat (3) cycleLen();
    check("badValleyOff", inr(off, OFFM, OFFM + 5), 1'b1);
    qualOk = 1'b1;
    repeat (2) cycleLen();
    qualOk = 1'b0;
    repeat (3) cycleLen();
    check("timerCleared", latchedHalt, 1'b0);
    waitFor(0, 400);
    check("shortLatch", latchedHalt, 1'b1);
    qualOk = 1'b1;
    supplyDrop(1'b0);
    check("stopKeepsLatch", latchedHalt, 1'b1);
    supplyDrop(1'b1);
    check("latchCleared", latchedHalt, 1'b0);
    shortedCoil = 1'b1;
    waitFor(0, 200);
    check("coilLatch", latchedHalt, 1'b1);
    check("coilDrive", switchDrive, 1'b0);
    shortedCoil = 1'b0;
    supplyDrop(1'b1);
    stopOk = 1'b0;
    repeat (5) @(negedge ref_clk);
    check("lockDrive", switchDrive, 1'b0);
    check("lockHvReq", hvReq, 1'b1);
    stopOk = 1'b1;
    cycleLen();
    check("restart", inr(on, 11, 15), 1'b1);
    dieHot = 1'b1;
    dieCool = 1'b0;
    waitFor(1, 50);
    check("dieHalt", safeRestartHalt, 1'b1);
    dieHot = 1'b0;
    supplyDrop(1'b0);
    check("stillWarm", switchDrive, 1'b0);
    dieCool = 1'b1;
    supplyDrop(1'b0);
    cycleLen();
    check("dieResume", safeRestartHalt, 1'b0);
    qualOk = 1'b0;
    cycleLen();
    check("offMaxOnly", inr(off, OFFM, OFFM + 5), 1'b1);
    nHigh = 1'b0;
    ramp = 4'ha;
    repeat (10) @(negedge ref_clk);
    check("rampPeak", peakLevel, 4'ha);
    nLow = 1'b0;
    repeat (10) @(negedge ref_clk);
    check("halfPeak", peakLevel, 4'h8);
    nAct = 1'b0;
    nDeact = 1'b0;
    waitFor(2, 40);
    check("dimmed", dimmedOff, 1'b1);
    check("dimDrive", switchDrive, 1'b0);
    nDeact = 1'b1;
    repeat (10) @(negedge ref_clk);
    check("undimmed", dimmedOff, 1'b0);
    check("dimNoLatch", latchedHalt, 1'b0);
    qualOk = 1'b1;
    waitFor(1, 120);
    check("ledHot", safeRestartHalt, 1'b1);
    nAct = 1'b1;
    nLow = 1'b1;
    nHigh = 1'b1;
    supplyDrop(1'b0);
    cycleLen();
    check("ledResume", safeRestartHalt, 1'b0);
    summarize();
  end
endmodule // testbench
`default_nettype wire
